//--- viwf_pkg.sv
package viwf_pkg;

  // Geometry
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SIZE_W = 3;
  localparam int SRC_W = 2;
  localparam int FIFO_DEPTH = 8;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_IDX_A = 8'h00;
  localparam logic [7:0] OFS_IDX_B = 8'h04;
  localparam logic [7:0] OFS_IDX_C = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_CTL = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control register fields
  localparam int CTL_WA_LSB = 0;
  localparam int CTL_WB_LSB = 4;
  localparam int CTL_WC_LSB = 8;
  localparam int CTL_A_DATA_BIT = 12;
  localparam int CTL_C_FROM_A_BIT = 13;
  localparam int CTL_WIDE_BIT = 14;
  localparam int CTL_HIST_BIT = 15;
  localparam int CTL_WESRC_LSB = 16;
  localparam int CTL_STASRC_LSB = 18;
  localparam logic [31:0] CTL_MASK = 32'h000FF777;

  // Flag register fields, inside each lane byte
  localparam int FLG_PRE_LSB = 0;
  localparam int FLG_CLR_LSB = 2;
  localparam int FLG_P_BIT = 4;
  localparam int FLG_R_BIT = 5;
  localparam int FLG_S_BIT = 6;
  localparam int FLG_W_BIT = 7;

  // Status register fields
  localparam int STA_CNT_LSB = 0;
  localparam int STA_PEND_BIT = 4;

  // Reset values
  localparam logic [31:0] RST_IDX = 32'h00000000;
  localparam logic [31:0] RST_FLAGS = 32'h00000000;
  localparam logic [31:0] RST_CTL = 32'h00000000;

  // Flag source selections
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_CARRY = 2'h1;
  localparam logic [1:0] SRC_BORROW = 2'h2;
  localparam logic [1:0] SRC_ZERO = 2'h3;

  // Forced lane values
  localparam logic [7:0] LANE_ONES = 8'hFF;
  localparam logic [7:0] LANE_ZERO = 8'h00;

  typedef logic [LANES-1:0][BYTE_W-1:0] viwf_idx_t;

  typedef struct packed {
    logic [LANES-1:0] carry;
    logic [LANES-1:0] zero;
  } viwf_alu_status_t;

  typedef struct packed {
    logic strobe;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] data;
    viwf_idx_t addr;
  } viwf_write_t;

  typedef enum logic [1:0] {
    CM_IDLE = 2'b01,
    CM_WRITE = 2'b10
  } viwf_commit_t;

endpackage

//--- viwf_idxgen.sv
`timescale 1ns/1ps
module viwf_idxgen #(
  parameter int LANES = 4,
  parameter int IW = 8,
  parameter int WW = 3,
  parameter logic [LANES*IW-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [LANES-1:0] sw_we_i,
  input wire logic [LANES*IW-1:0] sw_dat_i,
  input wire logic gen_i,
  input wire logic use_src_i,
  input wire logic [LANES*IW-1:0] src_i,
  input wire logic [WW-1:0] width_i,
  output logic [LANES*IW-1:0] idx_o
);

  logic [LANES*IW-1:0] idx_reg;
  logic [LANES*IW-1:0] idx_next;
  logic [IW-1:0] mask;

  // Width 0 selects the full index
  function automatic logic [IW-1:0] low_mask(input logic [WW-1:0] w);
    logic [IW-1:0] m;
    m = '0;
    for (int i = 0; i < IW; i++) begin
      if (w == '0 || i < int'(w)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    mask = low_mask(width_i);
    idx_next = idx_reg;
    for (int l = 0; l < LANES; l++) begin
      if (gen_i) begin
        // Upper bits hold a fixed base, low bits wrap [RULE20] [RULE6]
        idx_next[l*IW +: IW] = (idx_reg[l*IW +: IW] & ~mask) |
          ((use_src_i ? src_i[l*IW +: IW]
                      : IW'(idx_reg[l*IW +: IW] + 1'b1)) & mask); // [RULE11]
      end else if (sw_we_i[l]) begin
        idx_next[l*IW +: IW] = sw_dat_i[l*IW +: IW];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idx_reg <= RST_VAL;
    end else begin
      idx_reg <= idx_next;
    end
  end

  assign idx_o = idx_reg;

endmodule

//--- viwf_top.sv
`timescale 1ns/1ps
// What this block does
// [RULE1] Port A indices change only on A generation
// [RULE2] Port B indices change only on B generation
// [RULE3] Write indices change only on C generation
// [RULE4] Preset and clear sources change by software only
// [RULE5] C generation sets P/R/W; A sets S
// [RULE6] Three-bit width wraps index every eight steps
// [RULE7] Port A may take data bytes as indices
// [RULE8] Histogram bytes at 7:0 and 23:16, 2x16; the code takes all four data bytes as lane indices
// [RULE9] Histogram counts read, incremented, written back
// [RULE10] Write indices may copy port A indices
// [RULE11] A and write indices may increment per access
// [RULE12] Byte enables from ALU flags gate delayed write
// [RULE13] Delay FIFO gives one cycle before commit
// [RULE14] Preset forces flagged lanes to all ones
// [RULE15] Clear forces flagged lanes to zero
// [RULE16] Carry flags can load the preset flags
// [RULE17] Inverted carry can load the clear flags
// [RULE18] Index widths change by software only
// [RULE19] Indexed write pops pointer unless zero; the code also skips the pop in histogram mode
// [RULE20] Bits above index width stay unchanged
module viwf_top #(
  parameter int FIFO_DEPTH = viwf_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [viwf_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [viwf_pkg::DATA_W-1:0] wb_dat_i,
  output logic [viwf_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic gen_a_i,
  input wire logic gen_b_i,
  input wire logic gen_c_i,
  input wire logic [viwf_pkg::DATA_W-1:0] vec_data_i,
  input wire viwf_pkg::viwf_alu_status_t alu_status_i,
  input wire logic fifo_push_i,
  input wire logic [viwf_pkg::DATA_W-1:0] fifo_data_i,
  input wire logic [viwf_pkg::DATA_W-1:0] rd_a_data_i,
  output viwf_pkg::viwf_idx_t port_a_idx_o,
  output viwf_pkg::viwf_idx_t port_b_idx_o,
  output viwf_pkg::viwf_write_t wr_o
);

  localparam int LANES = viwf_pkg::LANES;
  localparam int DW = viwf_pkg::DATA_W;
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(FIFO_DEPTH - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic flag_sel(input logic [1:0] src,
                                    input viwf_pkg::viwf_alu_status_t st,
                                    input int lane,
                                    input logic off_val);
    case (src)
      viwf_pkg::SRC_OFF: return off_val;
      viwf_pkg::SRC_CARRY: return st.carry[lane];
      viwf_pkg::SRC_BORROW: return ~st.carry[lane];
      default: return st.zero[lane];
    endcase
  endfunction

  // In 2x16 mode the even lane flag governs both bytes of its pair
  function automatic logic [LANES-1:0] lane_expand(input logic [3:0] f,
                                                   input logic wide);
    return wide ? {f[2], f[2], f[0], f[0]} : f;
  endfunction

  function automatic logic [DW-1:0] byte_merge(input logic [DW-1:0] old,
                                               input logic [DW-1:0] nv,
                                               input logic [3:0] sel);
    logic [DW-1:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nv[b*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic req;
  logic wr_req;
  logic hit_a;
  logic hit_b;
  logic hit_c;
  logic hit_flags;
  logic hit_ctl;
  logic ack_reg;
  logic [DW-1:0] dat_reg;
  logic [DW-1:0] rd_mux;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_req = req & wb_we_i;
  assign hit_a = wr_req && (wb_adr_i == viwf_pkg::OFS_IDX_A);
  assign hit_b = wr_req && (wb_adr_i == viwf_pkg::OFS_IDX_B);
  assign hit_c = wr_req && (wb_adr_i == viwf_pkg::OFS_IDX_C);
  assign hit_flags = wr_req && (wb_adr_i == viwf_pkg::OFS_FLAGS);
  assign hit_ctl = wr_req && (wb_adr_i == viwf_pkg::OFS_CTL);

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [DW-1:0] ctl_reg;
  logic a_from_data;
  logic c_from_a;
  logic wide;
  logic hist;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg <= viwf_pkg::RST_CTL;
    end else if (hit_ctl) begin
      // Widths move only here, never through generation [RULE18]
      ctl_reg <= byte_merge(ctl_reg, wb_dat_i, wb_sel_i) &
                 viwf_pkg::CTL_MASK;
    end
  end

  assign a_from_data = ctl_reg[viwf_pkg::CTL_A_DATA_BIT];
  assign c_from_a = ctl_reg[viwf_pkg::CTL_C_FROM_A_BIT];
  assign wide = ctl_reg[viwf_pkg::CTL_WIDE_BIT];
  assign hist = ctl_reg[viwf_pkg::CTL_HIST_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Index generators

  logic [DW-1:0] idx_a;
  logic [DW-1:0] idx_b;
  logic [DW-1:0] idx_c;

  viwf_idxgen #(
    .LANES(LANES),
    .IW(viwf_pkg::BYTE_W),
    .WW(viwf_pkg::SIZE_W),
    .RST_VAL(viwf_pkg::RST_IDX)
  ) u_gen_a (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(wb_sel_i & {LANES{hit_a}}),
    .sw_dat_i(wb_dat_i),
    .gen_i(gen_a_i), // [RULE1]
    // Data bytes become indices, each lane its own byte, in 2x16 mode too [RULE7] [RULE8]
    .use_src_i(a_from_data),
    .src_i(vec_data_i),
    .width_i(ctl_reg[viwf_pkg::CTL_WA_LSB +: viwf_pkg::SIZE_W]),
    .idx_o(idx_a)
  );

  viwf_idxgen #(
    .LANES(LANES),
    .IW(viwf_pkg::BYTE_W),
    .WW(viwf_pkg::SIZE_W),
    .RST_VAL(viwf_pkg::RST_IDX)
  ) u_gen_b (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(wb_sel_i & {LANES{hit_b}}),
    .sw_dat_i(wb_dat_i),
    .gen_i(gen_b_i), // [RULE2]
    .use_src_i(1'b0),
    .src_i(idx_b),
    .width_i(ctl_reg[viwf_pkg::CTL_WB_LSB +: viwf_pkg::SIZE_W]),
    .idx_o(idx_b)
  );

  viwf_idxgen #(
    .LANES(LANES),
    .IW(viwf_pkg::BYTE_W),
    .WW(viwf_pkg::SIZE_W),
    .RST_VAL(viwf_pkg::RST_IDX)
  ) u_gen_c (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sw_we_i(wb_sel_i & {LANES{hit_c}}),
    .sw_dat_i(wb_dat_i),
    .gen_i(gen_c_i), // [RULE3]
    .use_src_i(c_from_a), // Reuse of read port A indices [RULE10]
    .src_i(idx_a),
    .width_i(ctl_reg[viwf_pkg::CTL_WC_LSB +: viwf_pkg::SIZE_W]),
    .idx_o(idx_c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Lane flags

  logic [LANES-1:0][1:0] pre_src_reg;
  logic [LANES-1:0][1:0] clr_src_reg;
  logic [LANES-1:0] pre_flag_reg;
  logic [LANES-1:0] clr_flag_reg;
  logic [LANES-1:0] cap_flag_reg;
  logic [LANES-1:0] we_flag_reg;
  logic [DW-1:0] flags_rd;

  // Generation is applied after the software write, so hardware wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int l = 0; l < LANES; l++) begin
        pre_src_reg[l] <= viwf_pkg::RST_FLAGS[l*8+viwf_pkg::FLG_PRE_LSB +: 2];
        clr_src_reg[l] <= viwf_pkg::RST_FLAGS[l*8+viwf_pkg::FLG_CLR_LSB +: 2];
        pre_flag_reg[l] <= viwf_pkg::RST_FLAGS[l*8+viwf_pkg::FLG_P_BIT];
        clr_flag_reg[l] <= viwf_pkg::RST_FLAGS[l*8+viwf_pkg::FLG_R_BIT];
        cap_flag_reg[l] <= viwf_pkg::RST_FLAGS[l*8+viwf_pkg::FLG_S_BIT];
        we_flag_reg[l] <= viwf_pkg::RST_FLAGS[l*8+viwf_pkg::FLG_W_BIT];
      end
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (hit_flags && wb_sel_i[l]) begin
          // Sources have no other writer [RULE4]
          pre_src_reg[l] <= wb_dat_i[l*8+viwf_pkg::FLG_PRE_LSB +: 2];
          clr_src_reg[l] <= wb_dat_i[l*8+viwf_pkg::FLG_CLR_LSB +: 2];
          pre_flag_reg[l] <= wb_dat_i[l*8+viwf_pkg::FLG_P_BIT];
          clr_flag_reg[l] <= wb_dat_i[l*8+viwf_pkg::FLG_R_BIT];
          cap_flag_reg[l] <= wb_dat_i[l*8+viwf_pkg::FLG_S_BIT];
          we_flag_reg[l] <= wb_dat_i[l*8+viwf_pkg::FLG_W_BIT];
        end
        if (gen_c_i) begin
          // Carry to preset, borrow to clear [RULE5] [RULE16] [RULE17]
          pre_flag_reg[l] <= flag_sel(pre_src_reg[l], alu_status_i, l, 1'b0);
          clr_flag_reg[l] <= flag_sel(clr_src_reg[l], alu_status_i, l, 1'b0);
          // Byte enables follow the ALU flags [RULE12]
          we_flag_reg[l] <= flag_sel(
            ctl_reg[viwf_pkg::CTL_WESRC_LSB +: 2], alu_status_i, l, 1'b1);
        end
        if (gen_a_i) begin
          cap_flag_reg[l] <= flag_sel(
            ctl_reg[viwf_pkg::CTL_STASRC_LSB +: 2], alu_status_i, l,
            1'b0); // [RULE5]
        end
      end
    end
  end

  always_comb begin
    flags_rd = '0;
    for (int l = 0; l < LANES; l++) begin
      flags_rd[l*8+viwf_pkg::FLG_PRE_LSB +: 2] = pre_src_reg[l];
      flags_rd[l*8+viwf_pkg::FLG_CLR_LSB +: 2] = clr_src_reg[l];
      flags_rd[l*8+viwf_pkg::FLG_P_BIT] = pre_flag_reg[l];
      flags_rd[l*8+viwf_pkg::FLG_R_BIT] = clr_flag_reg[l];
      flags_rd[l*8+viwf_pkg::FLG_S_BIT] = cap_flag_reg[l];
      flags_rd[l*8+viwf_pkg::FLG_W_BIT] = we_flag_reg[l];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write delay FIFO

  logic [FIFO_DEPTH-1:0][DW-1:0] fifo_mem;
  logic [PTR_W-1:0] fifo_ptr;
  logic push;
  logic pop;
  logic commit;

  // One slot is kept spare so a full pointer still reads as a count
  assign push = fifo_push_i && (fifo_ptr != PTR_MAX);
  assign pop = commit && !hist && (fifo_ptr != '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_mem <= '0;
    end else begin
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        if (pop) begin
          if (push && i == int'(fifo_ptr) - 1) begin
            fifo_mem[i] <= fifo_data_i;
          end else begin
            fifo_mem[i] <= fifo_mem[(i == FIFO_DEPTH - 1) ? i : i + 1];
          end
        end else if (push && i == int'(fifo_ptr)) begin
          fifo_mem[i] <= fifo_data_i;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fifo_ptr <= '0;
    end else if (push && !pop) begin
      fifo_ptr <= fifo_ptr + 1'b1;
    end else if (pop && !push) begin
      fifo_ptr <= fifo_ptr - 1'b1; // Both at once: unchanged [RULE19]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit sequence

  viwf_pkg::viwf_commit_t commit_reg;

  // Flags are formed at C generation and used one cycle later [RULE13]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      commit_reg <= viwf_pkg::CM_IDLE;
    end else begin
      case (commit_reg)
        viwf_pkg::CM_IDLE: begin
          if (gen_c_i) begin
            commit_reg <= viwf_pkg::CM_WRITE;
          end
        end
        viwf_pkg::CM_WRITE: begin
          if (!gen_c_i) begin
            commit_reg <= viwf_pkg::CM_IDLE;
          end
        end
        default: begin
          commit_reg <= viwf_pkg::CM_IDLE;
        end
      endcase
    end
  end

  assign commit = (commit_reg == viwf_pkg::CM_WRITE);

  logic [DW-1:0] base_data;
  logic [DW-1:0] wr_data_next;
  logic [LANES-1:0] p_eff;
  logic [LANES-1:0] r_eff;

  always_comb begin
    // Histogram counts come from port A, bumped on the fly [RULE9]
    base_data = hist ? {rd_a_data_i[31:16] + 16'h0001,
                        rd_a_data_i[15:0] + 16'h0001}
                     : fifo_mem[0];
    p_eff = lane_expand(pre_flag_reg, wide);
    r_eff = lane_expand(clr_flag_reg, wide);
    wr_data_next = base_data;
    for (int l = 0; l < LANES; l++) begin
      // Preset takes priority when both flags are set
      if (p_eff[l]) begin
        wr_data_next[l*8 +: 8] = viwf_pkg::LANE_ONES; // [RULE14]
      end else if (r_eff[l]) begin
        wr_data_next[l*8 +: 8] = viwf_pkg::LANE_ZERO; // [RULE15]
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_o <= '0;
    end else begin
      wr_o.strobe <= commit;
      if (commit) begin
        wr_o.be <= lane_expand(we_flag_reg, wide); // [RULE12]
        wr_o.data <= wr_data_next;
        wr_o.addr <= idx_c;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer

  always_comb begin
    rd_mux = '0;
    case (wb_adr_i)
      viwf_pkg::OFS_IDX_A: rd_mux = idx_a;
      viwf_pkg::OFS_IDX_B: rd_mux = idx_b;
      viwf_pkg::OFS_IDX_C: rd_mux = idx_c;
      viwf_pkg::OFS_FLAGS: rd_mux = flags_rd;
      viwf_pkg::OFS_CTL: rd_mux = ctl_reg;
      viwf_pkg::OFS_STATUS: begin
        rd_mux[viwf_pkg::STA_CNT_LSB +: PTR_W] = fifo_ptr;
        rd_mux[viwf_pkg::STA_PEND_BIT] = commit;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= req;
      if (req && !wb_we_i) begin
        dat_reg <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Index outputs come straight from the generator flops
  assign port_a_idx_o = idx_a;
  assign port_b_idx_o = idx_b;

endmodule

//--- viwf_rf_model.sv
`timescale 1ns/1ps
module viwf_rf_model (
  input wire logic clk_i,
  input wire viwf_pkg::viwf_idx_t rd_idx_i,
  input wire viwf_pkg::viwf_write_t wr_i,
  output logic [31:0] rd_data_o
);
  logic [7:0] mem [256];

  // Each entry starts out holding its own address
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i);
    end
  end

  // Read port A answers at once; a plain assign also follows table writes
  assign rd_data_o = {mem[rd_idx_i[3]], mem[rd_idx_i[2]],
                      mem[rd_idx_i[1]], mem[rd_idx_i[0]]};

  always @(posedge clk_i) begin
    if (wr_i.strobe) begin
      for (int l = 0; l < 4; l++) begin
        if (wr_i.be[l]) begin
          mem[wr_i.addr[l]] <= wr_i.data[8*l+:8];
        end
      end
    end
  end
endmodule

//--- viwf_checker.sv
`timescale 1ns/1ps
module viwf_checker #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [viwf_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [viwf_pkg::DATA_W-1:0] wb_dat_i,
  input wire logic [viwf_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic gen_a_i,
  input wire logic gen_b_i,
  input wire logic gen_c_i,
  input wire logic [viwf_pkg::DATA_W-1:0] vec_data_i,
  input wire viwf_pkg::viwf_alu_status_t alu_status_i,
  input wire logic fifo_push_i,
  input wire logic [viwf_pkg::DATA_W-1:0] fifo_data_i,
  input wire logic [viwf_pkg::DATA_W-1:0] rd_a_data_i,
  input wire viwf_pkg::viwf_idx_t port_a_idx_o,
  input wire viwf_pkg::viwf_idx_t port_b_idx_o,
  input wire viwf_pkg::viwf_write_t wr_o
);
  logic [31:0] ctl_sh;
  logic bw;
  logic rd_ctl;
  logic [7:0] a0_inc;
  logic [7:0] a0_src;

  function automatic logic [7:0] msk(input logic [2:0] w);
    return (w == 3'h0) ? 8'hFF : 8'((9'h001 << w) - 9'h001);
  endfunction

  assign bw = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_ctl = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o &&
                  wb_adr_i == viwf_pkg::OFS_CTL;
  assign a0_inc = (port_a_idx_o[0] & ~msk(ctl_sh[2:0])) |
                  ((port_a_idx_o[0] + 8'h01) & msk(ctl_sh[2:0]));
  assign a0_src = (port_a_idx_o[0] & ~msk(ctl_sh[2:0])) |
                  (vec_data_i[7:0] & msk(ctl_sh[2:0]));

  // Shadow of the control register, kept from bus writes alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_sh <= 32'h00000000;
    end else if (bw && wb_adr_i == viwf_pkg::OFS_CTL) begin
      for (int b = 0; b < 4; b++) begin
        if (wb_sel_i[b]) begin
          ctl_sh[8*b+:8] <= wb_dat_i[8*b+:8];
        end
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////
  a_idx_hold_a: assert property (!gen_a_i &&
    !(bw && wb_adr_i == viwf_pkg::OFS_IDX_A) |=> $stable(port_a_idx_o))
    else $error("port A indices moved without generation");
  b_idx_hold_a: assert property (!gen_b_i &&
    !(bw && wb_adr_i == viwf_pkg::OFS_IDX_B) |=> $stable(port_b_idx_o))
    else $error("port B indices moved without generation");
  a_incr_a: assert property (gen_a_i && !ctl_sh[12]
    |=> port_a_idx_o[0] == $past(a0_inc))
    else $error("port A lane 0 increment wrong");
  a_lookup_a: assert property (gen_a_i && ctl_sh[12]
    |=> port_a_idx_o[0] == $past(a0_src))
    else $error("port A lane 0 not loaded from data");
  commit_delay_a: assert property (gen_c_i |-> ##2 wr_o.strobe)
    else $error("commit strobe missing two cycles after generation");
  commit_cause_a: assert property (wr_o.strobe |-> $past(gen_c_i, 2))
    else $error("commit strobe without write generation");
  c_copy_a: assert property (gen_c_i && ctl_sh[13] &&
    ctl_sh[10:8] == 3'h0 && !gen_a_i |-> ##2
    (wr_o.addr == $past(port_a_idx_o, 2)))
    else $error("write indices not copied from port A");
  ctl_read_a: assert property (wb_ack_o && $past(rd_ctl)
    |-> wb_dat_o == (ctl_sh & viwf_pkg::CTL_MASK))
    else $error("control readback differs from written value");
endmodule

bind viwf_top viwf_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .gen_a_i(gen_a_i), .gen_b_i(gen_b_i), .gen_c_i(gen_c_i),
  .vec_data_i(vec_data_i), .alu_status_i(alu_status_i),
  .fifo_push_i(fifo_push_i), .fifo_data_i(fifo_data_i),
  .rd_a_data_i(rd_a_data_i), .port_a_idx_o(port_a_idx_o),
  .port_b_idx_o(port_b_idx_o), .wr_o(wr_o));

//--- vector_index_and_write_flags_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module vector_index_and_write_flags_tb_top;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, vec_data_i, fifo_data_i, rd_a_data_i;
  logic gen_a_i, gen_b_i, gen_c_i, fifo_push_i;
  viwf_pkg::viwf_alu_status_t alu_status_i;
  viwf_pkg::viwf_idx_t port_a_idx_o, port_b_idx_o;
  viwf_pkg::viwf_write_t wr_o;
  int n_mismatch, checks;

  viwf_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .gen_a_i(gen_a_i), .gen_b_i(gen_b_i),
    .gen_c_i(gen_c_i), .vec_data_i(vec_data_i), .alu_status_i(alu_status_i),
    .fifo_push_i(fifo_push_i), .fifo_data_i(fifo_data_i),
    .rd_a_data_i(rd_a_data_i), .port_a_idx_o(port_a_idx_o),
    .port_b_idx_o(port_b_idx_o), .wr_o(wr_o));
  viwf_rf_model u_rf (.clk_i(clk_i), .rd_idx_i(port_a_idx_o), .wr_i(wr_o),
    .rd_data_o(rd_a_data_i));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h00000000, r);
    `CHK(r, e)
  endtask

  task automatic push(input logic [31:0] d);
    @(posedge clk_i);
    fifo_push_i <= 1'b1;
    fifo_data_i <= d;
    @(posedge clk_i);
    fifo_push_i <= 1'b0;
  endtask

  // One write generation, then the commit two cycles later
  task automatic commit_chk(input logic [31:0] d, input logic [3:0] be,
                            input logic [31:0] a);
    @(posedge clk_i);
    gen_c_i <= 1'b1;
    gen_a_i <= 1'b0;
    @(posedge clk_i);
    gen_c_i <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
    `CHK(wr_o.strobe, 1'b1)
    `CHK(wr_o.data, d)
    `CHK(wr_o.be, be)
    `CHK(wr_o.addr, a)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(4 * i), 32'h00000000);
    end
    wr(viwf_pkg::OFS_CTL, 32'hFFFFFFFF);
    rd_chk(viwf_pkg::OFS_CTL, viwf_pkg::CTL_MASK);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h00000000);
    wr(viwf_pkg::OFS_CTL, 32'h00000000);
    $display("t_regs done");
  endtask

  task automatic t_wrap();
    wr(viwf_pkg::OFS_CTL, 32'h00000023);
    wr(viwf_pkg::OFS_IDX_A, 32'h38383838);
    wr(viwf_pkg::OFS_IDX_B, 32'hFFFFFFFF);
    @(posedge clk_i);
    gen_a_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    gen_a_i <= 1'b0;
    @(negedge clk_i);
    `CHK(port_a_idx_o, 32'h3D3D3D3D)
    @(posedge clk_i);
    gen_a_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    gen_a_i <= 1'b0;
    gen_b_i <= 1'b1;
    @(posedge clk_i);
    gen_b_i <= 1'b0;
    @(negedge clk_i);
    `CHK(port_a_idx_o, 32'h38383838)
    `CHK(port_b_idx_o, 32'hFCFCFCFC)
    rd_chk(viwf_pkg::OFS_IDX_C, 32'h00000000);
    rd_chk(viwf_pkg::OFS_CTL, 32'h00000023);
    $display("t_wrap done");
  endtask

  task automatic t_lookup();
    wr(viwf_pkg::OFS_CTL, 32'h000C1000);
    @(posedge clk_i);
    vec_data_i <= 32'h11223344;
    alu_status_i <= '{carry: 4'h0, zero: 4'b1010};
    gen_a_i <= 1'b1;
    @(posedge clk_i);
    gen_a_i <= 1'b0;
    @(negedge clk_i);
    `CHK(port_a_idx_o, 32'h11223344)
    rd_chk(viwf_pkg::OFS_FLAGS, 32'h40004000);
    $display("t_lookup done");
  endtask

  task automatic t_sat();
    wr(viwf_pkg::OFS_CTL, 32'h00000000);
    wr(viwf_pkg::OFS_FLAGS, 32'h01010101);
    push(32'h80402010);
    alu_status_i <= '{carry: 4'b0101, zero: 4'h0};
    commit_chk(32'h80FF20FF, 4'hF, 32'h01010101);
    rd_chk(viwf_pkg::OFS_STATUS, 32'h00000000);
    wr(viwf_pkg::OFS_FLAGS, 32'h08080808);
    wr(viwf_pkg::OFS_CTL, 32'h00010000);
    push(32'h11223344);
    push(32'h55667788);
    alu_status_i <= '{carry: 4'b0011, zero: 4'h0};
    commit_chk(32'h00003344, 4'b0011, 32'h02020202);
    rd_chk(viwf_pkg::OFS_STATUS, 32'h00000001);
    alu_status_i <= '{carry: 4'b0000, zero: 4'h0};
    commit_chk(32'h00000000, 4'h0, 32'h03030303);
    commit_chk(32'h00000000, 4'h0, 32'h04040404);
    rd_chk(viwf_pkg::OFS_STATUS, 32'h00000000);
    rd_chk(viwf_pkg::OFS_FLAGS, 32'h28282828);
    $display("t_sat done");
  endtask

  // Second pass reads back the counts written by the first
  task automatic t_hist();
    logic [31:0] exp_cnt [2];
    exp_cnt[0] = 32'h00060004;
    exp_cnt[1] = 32'h00070005;
    wr(viwf_pkg::OFS_FLAGS, 32'h00000000);
    wr(viwf_pkg::OFS_CTL, 32'h0000F000);
    vec_data_i <= 32'h00050003;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      gen_a_i <= 1'b1;
      commit_chk(exp_cnt[i], 4'hF, 32'h00050003);
      repeat (2) @(posedge clk_i);
    end
    $display("t_hist done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, gen_a_i, gen_b_i, gen_c_i} = 6'h00;
    {fifo_push_i, wb_adr_i, wb_sel_i} = 13'h00F;
    {wb_dat_i, vec_data_i, fifo_data_i} = 96'h0;
    alu_status_i = '{carry: 4'h0, zero: 4'h0};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_wrap();
    t_lookup();
    t_sat();
    t_hist();
    test_done();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
endmodule
